// ---- design/uthp_pkg.sv ----
// Package: register map, field layout and constants of the transmit path
package uthp_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] TX_DATA_OFF = 8'h00;
  localparam logic [7:0] SCRATCH_OFF = 8'h04;
  localparam logic [7:0] DIV_LO_OFF = 8'h08;
  localparam logic [7:0] DIV_HI_OFF = 8'h0C;
  localparam logic [7:0] LINE_CTRL_OFF = 8'h10;
  localparam logic [7:0] QUEUE_CTRL_OFF = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h1C;
  localparam logic [7:0] TX_STATUS_OFF = 8'h20;
  // Line control fields
  localparam int LC_WLEN_LSB = 0;
  localparam int LC_STOP_BIT = 2;
  localparam int LC_PAR_EN_BIT = 3;
  localparam int LC_PAR_EVEN_BIT = 4;
  // Queue control fields
  localparam int QC_QMODE_BIT = 0;
  localparam int QC_EMPTY_IE_BIT = 1;
  localparam int QC_LEVEL_LSB = 4;
  // Interrupt status bits
  localparam int IS_HOLD_EMPTY = 0;
  localparam int IS_QUEUE_LOW = 1;
  localparam int IS_SHIFT_DONE = 2;
  localparam int IRQ_BITS = 3;
  // Reset values
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [7:0] LINE_CTRL_RST = 8'h03;
  localparam logic [7:0] QUEUE_CTRL_RST = 8'h00;
  // Baud oversampling: ticks per serial bit
  localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hF;
  localparam logic [3:0] TICKS_HALF_M1 = 4'h7;
  // Index of the last data bit for a 5-bit word
  localparam logic [3:0] DATA_LAST_BASE = 4'h4;
endpackage : uthp_pkg

// ---- design/uthp_fifo.sv ----
// Holding queue: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module uthp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o,
  output logic [AW:0] count_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  wire push = wr_valid_i && wr_ready_o;
  wire pop = rd_valid_o && rd_ready_i;

  // Honest full and empty from the count
  assign wr_ready_o = (count != (AW+1)'(DEPTH));
  assign rd_valid_o = (count != '0);
  assign rd_data_o = mem[rptr];
  assign count_o = count;

  // Storage write
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wptr] <= wr_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : uthp_fifo
`default_nettype wire

// ---- design/uthp_tx.sv ----
// Transmit holding path: APB registers, holding queue, baud and shifter
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - An 8-bit scratch register reads back what software wrote.
// - Scratch accesses touch nothing else in the channel.
// - Holding stage is a 16-entry byte FIFO fed by host writes.
// - Bit timing comes from the clock divided by the programmed divisor.
// - Word length, parity and stop bits follow line control.
// - Oldest byte moves to the shifter only when the shifter is idle.
// - Shifter sends start, data, parity and stop bits on the line.
// - Simple mode: interrupt while holding stage empty; the empty enable bit is ignored.
// - Simple mode: writing a character clears the pending empty interrupt.
// - Queued mode: empty and level interrupts follow the queue control register.
// - Baud tick runs at 16x bit rate; a bit lasts 16 ticks.
// - Divisor is 16 bits in two byte latches loaded by software.
module uthp_tx
  import uthp_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic tx_o,
  output logic irq_o
);
  typedef enum {UTHP_IDLE, UTHP_START, UTHP_DATA, UTHP_PAR, UTHP_STOP}
    uthp_state_t;
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  // Asserts at once, releases two edges after the pin rises
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic [7:0] scratchpad_byte;
  logic [15:0] divisor;
  logic [7:0] line_ctrl;
  logic [7:0] queue_ctrl;
  logic [IRQ_BITS-1:0] irq_stat;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [AW:0] q_count;
  logic q_ready;
  logic q_valid;
  logic [7:0] q_data;
  uthp_state_t state;

  // Address match helper, used for every register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Access phase strobes; slave answers in the cycle after the first access cycle
  wire acc = psel_i && penable_i && !pready_o;
  wire wr = acc && pwrite_i;
  wire rd = acc && !pwrite_i;
  wire known = hit(paddr_i, TX_DATA_OFF) || hit(paddr_i, SCRATCH_OFF)
    || hit(paddr_i, DIV_LO_OFF) || hit(paddr_i, DIV_HI_OFF)
    || hit(paddr_i, LINE_CTRL_OFF) || hit(paddr_i, QUEUE_CTRL_OFF)
    || hit(paddr_i, IRQ_STAT_OFF) || hit(paddr_i, IRQ_MASK_OFF)
    || hit(paddr_i, TX_STATUS_OFF);
  wire wr_data = wr && hit(paddr_i, TX_DATA_OFF);
  wire push = wr_data && q_ready; // full queue drops the byte, flags error
  wire shift_idle = (state == UTHP_IDLE);
  wire hold_empty = !q_valid;
  wire qmode = queue_ctrl[QC_QMODE_BIT];
  wire [AW:0] q_level = (AW+1)'(queue_ctrl[7:QC_LEVEL_LSB]);
  // Status: count in 4:0, hold empty in 8, shifter idle in 9
  wire [31:0] status_word = {22'h00_0000, shift_idle, hold_empty,
    3'h0, 5'(q_count)};

  // Read data mux
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit(paddr_i, SCRATCH_OFF)) begin
      next_prdata = {24'h00_0000, scratchpad_byte};
    end
    if (hit(paddr_i, DIV_LO_OFF)) next_prdata = {24'h00_0000, divisor[7:0]};
    if (hit(paddr_i, DIV_HI_OFF)) next_prdata = {24'h00_0000, divisor[15:8]};
    if (hit(paddr_i, LINE_CTRL_OFF)) next_prdata = {24'h00_0000, line_ctrl};
    if (hit(paddr_i, QUEUE_CTRL_OFF)) next_prdata = {24'h00_0000, queue_ctrl};
    if (hit(paddr_i, IRQ_STAT_OFF)) next_prdata = {29'h0000_0000, irq_stat};
    if (hit(paddr_i, IRQ_MASK_OFF)) next_prdata = {29'h0000_0000, irq_mask};
    if (hit(paddr_i, TX_STATUS_OFF)) next_prdata = status_word;
  end

  // Bus answer registers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= acc;
      pslverr_o <= acc && (!known || (wr_data && !q_ready));
      prdata_o <= rd ? next_prdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic div_load;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      scratchpad_byte <= SCRATCH_RST;
      divisor <= DIV_RST;
      line_ctrl <= LINE_CTRL_RST;
      queue_ctrl <= QUEUE_CTRL_RST;
      irq_mask <= '0;
      div_load <= 1'b0;
    end else begin
      // Divisor write restarts the baud count one cycle later
      div_load <= wr && (hit(paddr_i, DIV_LO_OFF) || hit(paddr_i, DIV_HI_OFF));
      if (wr && hit(paddr_i, SCRATCH_OFF)) begin
        scratchpad_byte <= pwdata_i[7:0];
      end
      if (wr && hit(paddr_i, DIV_LO_OFF)) begin
        divisor[7:0] <= pwdata_i[7:0];
      end
      if (wr && hit(paddr_i, DIV_HI_OFF)) begin
        divisor[15:8] <= pwdata_i[7:0];
      end
      if (wr && hit(paddr_i, LINE_CTRL_OFF)) line_ctrl <= pwdata_i[7:0];
      if (wr && hit(paddr_i, QUEUE_CTRL_OFF)) queue_ctrl <= pwdata_i[7:0];
      if (wr && hit(paddr_i, IRQ_MASK_OFF)) irq_mask <= pwdata_i[IRQ_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Holding queue
  // ----------------------------------------------------------------------
  // Full queue refuses the byte; the bus answers with pslverr
  wire load = shift_idle && q_valid;
  uthp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_hold (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .wr_valid_i(wr_data),
    .wr_ready_o(q_ready),
    .wr_data_i(pwdata_i[7:0]),
    .rd_valid_o(q_valid),
    .rd_ready_i(load),
    .rd_data_o(q_data),
    .count_o(q_count)
  );

  // ----------------------------------------------------------------------
  // Baud generator: one tick per divisor clocks
  // ----------------------------------------------------------------------
  logic [15:0] baud_cnt;
  wire [15:0] div_eff = (divisor == 16'h0000) ? 16'h0001 : divisor;
  wire tick = (baud_cnt == 16'h0001);
  // A fresh divisor takes hold the cycle after its write, not after the old count
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt <= DIV_RST;
    end else if (div_load || tick) begin
      baud_cnt <= div_eff;
    end else begin
      baud_cnt <= baud_cnt - 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Shift stage
  // ----------------------------------------------------------------------
  logic [7:0] shreg;
  logic [3:0] tick_cnt;
  logic [3:0] bit_idx;
  logic parity;
  logic tx_line;
  wire [3:0] last_data = DATA_LAST_BASE + 4'(line_ctrl[LC_WLEN_LSB +: 2]);
  wire two_stop = line_ctrl[LC_STOP_BIT];
  wire short_word = (line_ctrl[LC_WLEN_LSB +: 2] == 2'b00);
  // 1.5 stop bits for 5-bit words, 2 otherwise, when stop select is set
  wire [3:0] stop_last = two_stop ? 4'h1 : 4'h0;
  wire bit_end = tick && (tick_cnt == TICKS_PER_BIT_M1);
  wire half_end = tick && (tick_cnt == TICKS_HALF_M1);
  wire stop_done = (bit_idx == stop_last) &&
    (two_stop && short_word && bit_idx == 4'h1 ? half_end : bit_end);
  wire shift_done = (state == UTHP_STOP) && stop_done;

  // Start bit may run short by up to one divisor period
  // Frame sequencer
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= UTHP_IDLE;
      shreg <= 8'h00;
      tick_cnt <= 4'h0;
      bit_idx <= 4'h0;
      parity <= 1'b0;
      tx_line <= 1'b1;
    end else begin
      unique case (state)
        UTHP_IDLE: begin
          tx_line <= 1'b1;
          tick_cnt <= 4'h0;
          if (load) begin
            shreg <= q_data;
            parity <= !line_ctrl[LC_PAR_EVEN_BIT];
            state <= UTHP_START;
            tx_line <= 1'b0;
          end
        end
        UTHP_START: begin
          if (tick) tick_cnt <= tick_cnt + 4'h1;
          if (bit_end) begin
            state <= UTHP_DATA;
            bit_idx <= 4'h0;
            tx_line <= shreg[0];
            parity <= parity ^ shreg[0];
            shreg <= {1'b0, shreg[7:1]};
          end
        end
        UTHP_DATA: begin
          if (tick) tick_cnt <= tick_cnt + 4'h1;
          if (bit_end) begin
            if (bit_idx == last_data) begin
              bit_idx <= 4'h0;
              state <= line_ctrl[LC_PAR_EN_BIT] ? UTHP_PAR : UTHP_STOP;
              tx_line <= line_ctrl[LC_PAR_EN_BIT] ? parity : 1'b1;
            end else begin
              bit_idx <= bit_idx + 4'h1;
              tx_line <= shreg[0];
              parity <= parity ^ shreg[0];
              shreg <= {1'b0, shreg[7:1]};
            end
          end
        end
        UTHP_PAR: begin
          if (tick) tick_cnt <= tick_cnt + 4'h1;
          if (bit_end) begin
            state <= UTHP_STOP;
            tx_line <= 1'b1;
          end
        end
        UTHP_STOP: begin
          if (tick) tick_cnt <= tick_cnt + 4'h1;
          if (shift_done) begin
            state <= UTHP_IDLE;
            tick_cnt <= 4'h0;
          end else if (bit_end) begin
            bit_idx <= bit_idx + 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ----------------------------------------------------------------------
  // Empty after this edge: a landing push must not re-set it
  wire empty_ev = hold_empty && !push;
  wire ev_hold = qmode ? (empty_ev && queue_ctrl[QC_EMPTY_IE_BIT])
                       : empty_ev;
  wire ev_low = qmode && (q_count <= q_level) && !hold_empty;
  logic [IRQ_BITS-1:0] events;
  assign events = {shift_done, ev_low, ev_hold};
  wire [IRQ_BITS-1:0] w1c = (wr && hit(paddr_i, IRQ_STAT_OFF))
    ? pwdata_i[IRQ_BITS-1:0] : '0;
  // A character write retires a pending empty in simple mode
  wire [IRQ_BITS-1:0] push_clr = (push && !qmode)
    ? IRQ_BITS'(1 << IS_HOLD_EMPTY) : '0;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(w1c | push_clr)) | events;
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  assign tx_o = tx_line;
endmodule : uthp_tx
`default_nettype wire

// ---- tb/uthp_tx_chk.sv ----
// Checker: bus, serial line and interrupt properties of the tx path
`timescale 1ns/1ps
`default_nettype none
module uthp_tx_chk
  import uthp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic tx_o,
  input wire logic irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] scr;
  logic mask_on;
  wire wr_ok = pready_o && pwrite_i && !pslverr_o;
  wire mapped = paddr_i <= TX_STATUS_OFF && paddr_i[1:0] == 2'h0;
  // Shadows of scratch and mask writes
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scr <= SCRATCH_RST;
      mask_on <= 1'b0;
    end else if (wr_ok && paddr_i == SCRATCH_OFF) begin
      scr <= pwdata_i[7:0];
    end else if (wr_ok && paddr_i == IRQ_MASK_OFF) begin
      mask_on <= |pwdata_i[2:0];
    end
  end
  AST_READY_WAIT: assert property (
    psel_i && penable_i && !pready_o |=> pready_o) else $error("no answer");
  AST_READY_PULSE: assert property (
    pready_o |=> !pready_o) else $error("ready too long");
  AST_RDATA_IDLE: assert property (
    !pready_o |-> prdata_o == 32'h0000_0000) else $error("stray rdata");
  AST_ERR_READY: assert property (
    pslverr_o |-> pready_o) else $error("error without ready");
  AST_UNMAPPED: assert property (
    pready_o && !mapped |-> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access");
  AST_SCRATCH_RB: assert property (
    pready_o && !pwrite_i && paddr_i == SCRATCH_OFF
    |-> prdata_o == {24'h00_0000, scr}) else $error("scratch readback");
  AST_START_BIT: assert property (
    $fell(tx_o) |-> !tx_o [*8]) else $error("short low bit");
  AST_MARK_BIT: assert property (
    $rose(tx_o) |-> tx_o [*8]) else $error("short high bit");
  AST_IRQ_MASK: assert property (
    !mask_on && $past(!mask_on) |-> !irq_o) else $error("masked irq");
endmodule : uthp_tx_chk
bind uthp_tx uthp_tx_chk u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_o(tx_o), .irq_o(irq_o));
`default_nettype wire

// ---- tb/uthp_line_rx.sv ----
// Serial line model: receives 8-bit, 1-stop frames from the tx pin
`timescale 1ns/1ps
`default_nettype none
module uthp_line_rx #(
  parameter int BIT_CLKS = 32
) (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic [7:0] byte_o,
  output int frames_o,
  output int frame_errs_o
);
  // Start edge, mid-bit sampling, stop check
  initial begin
    byte_o = 8'h00;
    frames_o = 0;
    frame_errs_o = 0;
    forever begin
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(posedge mclk_i);
      if (line_i) frame_errs_o++;
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge mclk_i);
        byte_o[i] = line_i;
      end
      repeat (BIT_CLKS) @(posedge mclk_i);
      if (!line_i) frame_errs_o++;
      frames_o++;
    end
  end
endmodule : uthp_line_rx
`default_nettype wire

// ---- tb/uthp_tx_tb_top.sv ----
// Testbench: APB master, line receiver and scenario sequence
`timescale 1ns/1ps
`default_nettype none
module uthp_tx_tb_top
  import uthp_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, tx, irq, err;
  logic [7:0] rx_byte;
  logic [7:0] pat [3] = '{8'hA5, 8'h5A, 8'hFF};
  int frames, ferrs;
  int errors = 0;
  int samples_checked = 0;
  always #2 mclk = ~mclk;
  uthp_tx uut (.mclk_i(mclk), .reset_n_i(reset_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_o(tx), .irq_o(irq));
  uthp_line_rx #(.BIT_CLKS(32)) u_rx (.mclk_i(mclk), .line_i(tx),
    .byte_o(rx_byte), .frames_o(frames), .frame_errs_o(ferrs));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wait_frame(input int n, input logic [7:0] exp);
    int t;
    t = 0;
    while (frames < n && t < 2000) begin
      @(posedge mclk);
      t++;
    end
    if (t >= 2000) errors++;
    chk("rx byte", {24'h00_0000, rx_byte}, {24'h00_0000, exp});
  endtask : wait_frame
  task automatic stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Watchdog against a hung handshake or line
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  // Scenario sequence
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("tx idle", 32'(tx), 32'h0000_0001);
    apb(1'b0, TX_STATUS_OFF, 32'h0000_0000);
    chk("reset status", rd, 32'h0000_0300);
    foreach (pat[i]) begin
      apb(1'b1, SCRATCH_OFF, {24'h00_0000, pat[i]});
      apb(1'b0, SCRATCH_OFF, 32'h0000_0000);
      chk("scratch", rd, {24'h00_0000, pat[i]});
      apb(1'b0, TX_STATUS_OFF, 32'h0000_0000);
      chk("status", rd, 32'h0000_0300);
      chk("irq", 32'(irq), 32'h0000_0000);
    end
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk("unmapped err", 32'(err), 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, DIV_LO_OFF, 32'h0000_0002);
    apb(1'b1, DIV_HI_OFF, 32'h0000_0000);
    apb(1'b1, IRQ_MASK_OFF, 32'h0000_0001);
    chk("irq empty", 32'(irq), 32'h0000_0001);
    for (int i = 0; i < 18; i++) begin
      apb(1'b1, TX_DATA_OFF, 32'(i + 48));
      chk("push err", 32'(err), 32'(i == 17));
      if (i == 1) chk("irq write", 32'(irq), 32'h0000_0000);
    end
    apb(1'b0, TX_STATUS_OFF, 32'h0000_0000);
    chk("full status", rd, 32'h0000_0010);
    for (int i = 0; i < 17; i++) wait_frame(i + 1, 8'(i + 48));
    repeat (40) @(posedge mclk);
    chk("frame errs", 32'(ferrs), 32'h0000_0000);
    apb(1'b0, TX_STATUS_OFF, 32'h0000_0000);
    chk("drained status", rd, 32'h0000_0300);
    chk("irq drained", 32'(irq), 32'h0000_0001);
    apb(1'b1, IRQ_MASK_OFF, 32'h0000_0000);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    apb(1'b1, QUEUE_CTRL_OFF, 32'h0000_0011);
    apb(1'b1, TX_DATA_OFF, 32'h0000_003C);
    apb(1'b0, IRQ_STAT_OFF, 32'h0000_0000);
    chk("level stat", rd & 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, IRQ_MASK_OFF, 32'h0000_0002);
    chk("irq level", 32'(irq), 32'h0000_0001);
    wait_frame(18, 8'h3C);
    stop_test();
  end
endmodule : uthp_tx_tb_top
`default_nettype wire
